// >>> logic/host_ctrl.sv
// power-manager host control ports: domain enables, feedback ports, supply warning, interrupt
`timescale 1ns/1ps
`default_nettype none
module host_ctrl
  import host_ctrl_pkg::*;
#(
  parameter int unsigned WAKE_MIN = WAKE_MIN_CYC
) (
  // clock and reset
  input  wire logic             CLK,
  input  wire logic             RST_N,
  // host pins
  input  wire logic             MAIN_EN_PIN,
  input  wire logic             AUX_EN_PIN,
  input  wire logic             FB2_I,
  output logic                  FB2_O,
  output logic                  FB2_OE,
  input  wire logic             FB3_I,
  output logic                  FB1_O,
  output logic                  SUPPLY_LOW_N,
  output logic                  IRQ_OUT,
  // configuration
  input  wire logic             MAIN_POL,
  input  wire logic             MAIN_WEN,
  input  wire logic             AUX_POL,
  input  wire logic             AUX_WEN,
  input  wire logic             FB1_MODE,
  input  wire logic             FB1_LEVEL,
  input  wire logic             FB2_MODE,
  input  wire logic             FB2_POL,
  input  wire logic             FB3_MODE,
  input  wire logic             FB3_POL,
  input  wire logic             SUPPLY_SRC_SEL,
  input  wire logic             IRQ_POL,
  // enable register mirrors
  input  wire logic             MAIN_BIT_WR,
  input  wire logic             MAIN_BIT_WDATA,
  input  wire logic             AUX_BIT_WR,
  input  wire logic             AUX_BIT_WDATA,
  output logic                  MAIN_EN_BIT,
  output logic                  AUX_EN_BIT,
  input  wire logic             SYSTEM_DOMAIN_ENABLE_PIN_BIT,
  // sequencer and system state
  input  wire logic             SEQ_BUSY,
  input  wire logic             SEQ_DONE,
  input  wire logic             SEQ_DVC,
  input  wire logic             IDLE_STATE,
  input  wire logic             WAKE_VALID,
  output logic                  SEQ_PU_MAIN,
  output logic                  SEQ_PU_AUX,
  output logic                  SEQ_PD_MAIN,
  output logic                  SEQ_PD_AUX,
  output logic                  WAKEUP,
  output logic                  WDOG_KICK,
  // supply and monitoring
  input  wire logic             BELOW_UPPER,
  input  wire logic             BELOW_LOWER,
  input  wire logic             ADC_VALID,
  input  wire logic [ADC_W-1:0] ADC_RESULT,
  input  wire logic [ADC_W-1:0] ADC_THRESH,
  input  wire logic             ADC_MON_EN,
  input  wire logic             REG_OUT_RANGE,
  output logic                  FAULT_PD,
  output logic                  FULL_RESET,
  // vibrator
  input  wire logic             VIB_ACTIVE,
  output logic                  MOTOR_RUN,
  // events
  input  wire logic [EVT_W-1:0] EVT_MASK,
  input  wire logic [EVT_W-1:0] EVT_CLR,
  input  wire logic             EVT_READING,
  output logic      [EVT_W-1:0] EVT_STATUS
);
  localparam int unsigned WCW = $clog2(WAKE_MIN + 1);
  localparam logic [WCW-1:0] WAKE_LAST = WCW'(WAKE_MIN);

  logic [SY_W-1:0] sy;
  consec_if        cif ();

  // every asynchronous input passes two flops first
  pin_sync #(.W(SY_W)) u_sync (
    .clk   (CLK),
    .rst_n (RST_N),
    .d     ({BELOW_LOWER, BELOW_UPPER, FB3_I, FB2_I, AUX_EN_PIN, MAIN_EN_PIN}),
    .q     (sy)
  );

  // ADC supply monitor filter
  assign cif.sample_valid = ADC_VALID;
  assign cif.below        = ADC_RESULT < ADC_THRESH;
  consec_filter #(.N(ADC_CONSEC)) u_adc (
    .clk   (CLK),
    .rst_n (RST_N),
    .c     (cif)
  );

  // polarity-corrected pin levels
  logic main_act;
  logic aux_act;
  logic ka_act;
  logic brk_act;
  assign main_act = MAIN_POL ? sy[SY_MAIN] : ~sy[SY_MAIN];
  assign aux_act  = AUX_POL ? sy[SY_AUX] : ~sy[SY_AUX];
  assign ka_act   = FB2_POL ? sy[SY_FB2] : ~sy[SY_FB2];
  assign brk_act  = FB3_POL ? sy[SY_FB3] : ~sy[SY_FB3];

  // ---------------- domain enables and power-down order ----------------
  pd_state_t pd_r;
  pd_state_t pd_nxt;
  logic main_last_r;
  logic main_last_nxt;
  logic aux_last_r;
  logic aux_last_nxt;
  logic main_bit_nxt;
  logic aux_bit_nxt;
  logic pu_main_nxt;
  logic pu_aux_nxt;
  logic pd_main_nxt;
  logic pd_aux_nxt;
  logic main_rise;
  logic aux_rise;
  logic hold;
  logic [1:0] prime_r;
  logic [1:0] prime_nxt;
  logic       primed;

  // sequencer work in flight freezes the enables; a pin change is seen once it ends, a register write is dropped
  assign hold = SEQ_BUSY | (pd_r != PD_IDLE);
  // the two-flop path shows reset zeros for two edges, which would read as an edge on an active-low pin
  assign primed    = prime_r == 2'h3;
  assign prime_nxt = primed ? prime_r : prime_r + 2'h1;

  always_comb begin
    pd_nxt        = pd_r;
    main_last_nxt = main_last_r;
    aux_last_nxt  = aux_last_r;
    main_bit_nxt  = MAIN_EN_BIT;
    aux_bit_nxt   = AUX_EN_BIT;
    pu_main_nxt   = 1'b0;
    pu_aux_nxt    = 1'b0;
    pd_main_nxt   = 1'b0;
    pd_aux_nxt    = 1'b0;
    main_rise     = 1'b0;
    aux_rise      = 1'b0;
    unique case (pd_r)
      PD_IDLE: begin
        if (!primed) begin
          // synchroniser output not yet valid: follow it without raising an edge
          main_last_nxt = main_act;
          aux_last_nxt  = aux_act;
        end else if (!SEQ_BUSY) begin
          // pin change wins over a register write in the same cycle
          if (main_act != main_last_r) begin
            main_last_nxt = main_act;
            main_bit_nxt  = main_act;
            main_rise     = main_act;
          end else if (MAIN_BIT_WR && MAIN_BIT_WDATA != MAIN_EN_BIT) begin
            main_bit_nxt = MAIN_BIT_WDATA;
          end
          if (aux_act != aux_last_r) begin
            aux_last_nxt = aux_act;
            aux_bit_nxt  = aux_act;
            aux_rise     = aux_act;
          end else if (AUX_BIT_WR && AUX_BIT_WDATA != AUX_EN_BIT) begin
            aux_bit_nxt = AUX_BIT_WDATA;
          end
          if (MAIN_EN_BIT && !main_bit_nxt) begin
            // aux goes down first, main after the sequencer reports done
            aux_bit_nxt = 1'b0;
            pd_aux_nxt  = 1'b1;
            pd_nxt      = PD_WAIT;
          end else begin
            pu_main_nxt = !MAIN_EN_BIT && main_bit_nxt;
            pu_aux_nxt  = !AUX_EN_BIT && aux_bit_nxt;
            pd_aux_nxt  = AUX_EN_BIT && !aux_bit_nxt;
          end
        end
      end
      PD_AUX: begin
        pd_aux_nxt = 1'b1;
        pd_nxt     = PD_WAIT;
      end
      PD_WAIT: begin
        if (SEQ_DONE) begin
          pd_main_nxt = 1'b1;
          pd_nxt      = PD_MAIN;
        end
      end
      PD_MAIN: begin
        pd_nxt = PD_IDLE;
      end
      default: begin
        pd_nxt = PD_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pd_r        <= PD_IDLE;
      prime_r     <= 2'h0;
      main_last_r <= 1'b0;
      aux_last_r  <= 1'b0;
      MAIN_EN_BIT <= 1'b0;
      AUX_EN_BIT  <= 1'b0;
      SEQ_PU_MAIN <= 1'b0;
      SEQ_PU_AUX  <= 1'b0;
      SEQ_PD_MAIN <= 1'b0;
      SEQ_PD_AUX  <= 1'b0;
    end else begin
      pd_r        <= pd_nxt;
      prime_r     <= prime_nxt;
      main_last_r <= main_last_nxt;
      aux_last_r  <= aux_last_nxt;
      MAIN_EN_BIT <= main_bit_nxt;
      AUX_EN_BIT  <= aux_bit_nxt;
      SEQ_PU_MAIN <= pu_main_nxt;
      SEQ_PU_AUX  <= pu_aux_nxt;
      SEQ_PD_MAIN <= pd_main_nxt;
      SEQ_PD_AUX  <= pd_aux_nxt;
    end
  end

  // ---------------- supply, wakeup, feedback ports ----------------
  logic upper_d_r;
  logic warn_set;
  logic supply_low;
  logic ka_d_r;
  logic wake_ind_r;
  logic wake_ind_nxt;
  logic [WCW-1:0] wcnt_r;
  logic [WCW-1:0] wcnt_nxt;
  logic wake_nxt;
  logic fb1_nxt;
  logic fb2_good;
  logic motor_nxt;

  // supply warning on the entry below the upper threshold
  assign warn_set   = sy[SY_UPPER] && !upper_d_r;
  assign supply_low = SUPPLY_SRC_SEL ? cif.state_low : sy[SY_UPPER];
  assign fb2_good   = ADC_MON_EN && !REG_OUT_RANGE;

  always_comb begin
    wake_nxt     = IDLE_STATE && ((main_rise && MAIN_WEN) || (aux_rise && AUX_WEN) || warn_set);
    wake_ind_nxt = wake_ind_r;
    wcnt_nxt     = wcnt_r;
    if (wake_ind_r) begin
      if (wcnt_r != WAKE_LAST) begin
        wcnt_nxt = wcnt_r + WCW'(1);
      end
      // release needs both the system enable and the least pulse time
      if (SYSTEM_DOMAIN_ENABLE_PIN_BIT && wcnt_r == WAKE_LAST) begin
        wake_ind_nxt = 1'b0;
      end
    end else if (IDLE_STATE && WAKE_VALID) begin
      wake_ind_nxt = 1'b1;
      wcnt_nxt     = WCW'(1);
    end
    fb1_nxt = FB1_MODE ? (SEQ_BUSY || SEQ_DVC) : wake_ind_nxt;
    fb1_nxt = FB1_LEVEL ? fb1_nxt : ~fb1_nxt;
    // brake pin gates the motor only in brake mode with the driver on
    motor_nxt = VIB_ACTIVE && !(FB3_MODE && brk_act);
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      upper_d_r    <= 1'b0;
      ka_d_r       <= 1'b0;
      wake_ind_r   <= 1'b0;
      wcnt_r       <= '0;
      WAKEUP       <= 1'b0;
      FB1_O        <= 1'b0;
      FB2_O        <= 1'b0;
      FB2_OE       <= 1'b0;
      WDOG_KICK    <= 1'b0;
      MOTOR_RUN    <= 1'b0;
      SUPPLY_LOW_N <= 1'b1;
      FAULT_PD     <= 1'b0;
      FULL_RESET   <= 1'b0;
    end else begin
      upper_d_r    <= sy[SY_UPPER];
      ka_d_r       <= ka_act;
      wake_ind_r   <= wake_ind_nxt;
      wcnt_r       <= wcnt_nxt;
      WAKEUP       <= wake_nxt;
      FB1_O        <= fb1_nxt;
      FB2_O        <= 1'b0;
      FB2_OE       <= !FB2_MODE && !fb2_good; // open drain pulls low when not good, outside keep-alive mode (FB2_MODE low)
      WDOG_KICK    <= FB2_MODE && primed && ka_act && !ka_d_r;
      MOTOR_RUN    <= motor_nxt;
      SUPPLY_LOW_N <= !supply_low;
      FAULT_PD     <= warn_set;
      FULL_RESET   <= sy[SY_LOWER];
    end
  end

  // ---------------- events and interrupt ----------------
  logic [EVT_W-1:0] raw_evt;
  logic [EVT_W-1:0] pend_r;
  logic [EVT_W-1:0] pend_nxt;
  logic [EVT_W-1:0] evt_nxt;
  logic             irq_nxt;
  logic             present;

  always_comb begin
    raw_evt           = '0;
    raw_evt[EVT_MAIN] = main_rise;
    raw_evt[EVT_AUX]  = aux_rise;
    raw_evt[EVT_VDD]  = warn_set;
    // held while a read is open or the sequencer walks its slots
    present  = !EVT_READING && !SEQ_BUSY;
    pend_nxt = pend_r | raw_evt;
    evt_nxt  = EVT_STATUS & ~EVT_CLR;
    if (present) begin
      evt_nxt  = evt_nxt | pend_nxt; // set wins over clear
      pend_nxt = '0;
    end
    irq_nxt = |(evt_nxt & ~EVT_MASK);
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pend_r     <= EVT_RST;
      EVT_STATUS <= EVT_RST;
      IRQ_OUT    <= 1'b1;
    end else begin
      pend_r     <= pend_nxt;
      EVT_STATUS <= evt_nxt;
      IRQ_OUT    <= IRQ_POL ? irq_nxt : ~irq_nxt;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_main_off;
    MAIN_EN_BIT ##1 !MAIN_EN_BIT;
  endsequence
  sequence s_aux_then_wait;
    SEQ_PD_AUX && !SEQ_PD_MAIN && pd_r == PD_WAIT ##1 !SEQ_PD_AUX;
  endsequence

  property p_pd_order;
    s_main_off |-> s_aux_then_wait;
  endproperty
  a_pd_order: assert property (p_pd_order) else $error("aux power-down not first");

  property p_pd_main;
    pd_r == PD_WAIT && SEQ_DONE |=> SEQ_PD_MAIN;
  endproperty
  a_pd_main: assert property (p_pd_main) else $error("main power-down missing");

  property p_hold;
    SEQ_BUSY |=> $stable(MAIN_EN_BIT) && $stable(AUX_EN_BIT);
  endproperty
  a_hold: assert property (p_hold) else $error("enable changed while busy");

  property p_wake_min;
    $rose(wake_ind_r) |-> wake_ind_r [*8];
  endproperty
  a_wake_min: assert property (p_wake_min) else $error("wakeup pulse too short");

  property p_wake_rel;
    wake_ind_r && !SYSTEM_DOMAIN_ENABLE_PIN_BIT |=> wake_ind_r;
  endproperty
  a_wake_rel: assert property (p_wake_rel) else $error("wakeup released early");

  property p_pend;
    (SEQ_BUSY || EVT_READING) |=> (EVT_STATUS & ~$past(EVT_STATUS)) == 3'h0;
  endproperty
  a_pend: assert property (p_pend) else $error("event presented during hold");

  property p_irq;
    ##1 IRQ_OUT == ($past(IRQ_POL) ? |(EVT_STATUS & ~$past(EVT_MASK)) : ~|(EVT_STATUS & ~$past(EVT_MASK)));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt output wrong");

  property p_kick;
    WDOG_KICK |=> !WDOG_KICK;
  endproperty
  a_kick: assert property (p_kick) else $error("kick not a single pulse");

  property p_fault;
    warn_set |=> FAULT_PD ##1 !FAULT_PD;
  endproperty
  a_fault: assert property (p_fault) else $error("fault power-down not pulsed");

  property p_motor;
    !VIB_ACTIVE |=> !MOTOR_RUN;
  endproperty
  a_motor: assert property (p_motor) else $error("motor runs with driver off");
endmodule
`default_nettype wire

// >>> logic/host_ctrl_pkg.sv
// shared constants for the power-manager host control port logic
package host_ctrl_pkg;
  localparam int unsigned CLK_MHZ      = 40;          // core clock rate in MHz
  localparam int unsigned WAKE_MIN_US  = 500;         // least wakeup indication pulse in us
  localparam int unsigned WAKE_MIN_CYC = WAKE_MIN_US * CLK_MHZ;
  localparam int unsigned ADC_CONSEC   = 3;           // consecutive ADC results to change state
  localparam int unsigned ADC_W        = 10;          // ADC result width
  // event bit positions
  localparam int unsigned EVT_MAIN     = 0;
  localparam int unsigned EVT_AUX      = 1;
  localparam int unsigned EVT_VDD      = 2;
  localparam int unsigned EVT_W        = 3;
  // synchronised pin vector positions
  localparam int unsigned SY_MAIN      = 0;
  localparam int unsigned SY_AUX       = 1;
  localparam int unsigned SY_FB2       = 2;
  localparam int unsigned SY_FB3       = 3;
  localparam int unsigned SY_UPPER     = 4;
  localparam int unsigned SY_LOWER     = 5;
  localparam int unsigned SY_W         = 6;
  // reset values
  localparam logic [EVT_W-1:0] EVT_RST = 3'h0;
  // power-down sequencing states
  typedef enum logic [3:0] {
    PD_IDLE = 4'h1,
    PD_AUX  = 4'h2,
    PD_WAIT = 4'h4,
    PD_MAIN = 4'h8
  } pd_state_t;
endpackage

// >>> logic/consec_if.sv
// carrier between the top and the consecutive-result filter
`timescale 1ns/1ps
`default_nettype none
interface consec_if;
  logic sample_valid;
  logic below;
  logic state_low;
  modport mgr  (output sample_valid, output below, input state_low);
  modport filt (input sample_valid, input below, output state_low);
endinterface
`default_nettype wire

// >>> logic/pin_sync.sv
// two-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // pins and synchronised copy
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// >>> logic/consec_filter.sv
// state flips only after N consecutive results on the other side of the threshold
`timescale 1ns/1ps
`default_nettype none
module consec_filter #(
  parameter int unsigned N = 3
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // sample stream and filtered state
  consec_if.filt    c
);
  localparam int unsigned CW = $clog2(N + 1);
  localparam logic [CW-1:0] LAST = CW'(N - 1);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          low_r;
  logic          low_nxt;

  // a result agreeing with the present state restarts the run
  always_comb begin
    cnt_nxt = cnt_r;
    low_nxt = low_r;
    if (c.sample_valid) begin
      if (c.below != low_r) begin
        if (cnt_r == LAST) begin
          low_nxt = c.below;
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r + CW'(1);
        end
      end else begin
        cnt_nxt = '0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      low_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      low_r <= low_nxt;
    end
  end

  assign c.state_low = low_r;
endmodule
`default_nettype wire

// >>> testbench/host_model.sv
// host processor model: enable, keep-alive and brake pins
`timescale 1ns/1ps
`default_nettype none
module host_model #(
  parameter int KA_HALF = 3000
) (
  // clock
  input  wire logic clk,
  // requests from the bench
  input  wire logic want_sys,
  input  wire logic want_main,
  input  wire logic want_aux,
  input  wire logic want_brake,
  input  wire logic kick_req,
  // pins toward the device, and the keep-alive busy flag for the bench
  output logic      system_domain_enable_pin,
  output logic      main_pin,
  output logic      aux_pin,
  output logic      brake_pin,
  output logic      ka_pin,
  output logic      ka_busy
);
  int cnt = 0;

  // pins start passive so no enable edge is seen at power-up
  initial begin
    {system_domain_enable_pin, main_pin, aux_pin, brake_pin, ka_pin} = 5'h00;
  end

  // main pin waits on system enable, so the domain order can never be broken
  always @(posedge clk) begin
    system_domain_enable_pin    <= want_sys;
    main_pin  <= want_main & system_domain_enable_pin;
    aux_pin   <= want_aux;
    brake_pin <= want_brake;
    ka_pin    <= cnt > KA_HALF;
    if (cnt != 0)
      cnt <= cnt - 1;
    else if (kick_req)
      cnt <= 2 * KA_HALF;
  end

  // busy until the full high plus low keep-alive cycle is over
  assign ka_busy = (cnt != 0) || ka_pin;
endmodule
`default_nettype wire

// >>> testbench/host_ctrl_tb_top.sv
// self-checking bench for the host control port logic
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_tb_top;
  import host_ctrl_pkg::*;
  localparam int unsigned WMIN = 20;
  localparam logic [9:0] CORNER [6] = '{10'h1FF, 10'h1FF, 10'h200, 10'h1FF, 10'h1FF, 10'h1FF};
  // device inputs, with the EVT_STATUS output last
  logic             CLK, RST_N, MAIN_EN_PIN, AUX_EN_PIN, FB2_I, FB3_I, SYSTEM_DOMAIN_ENABLE_PIN_BIT, MAIN_POL, MAIN_WEN;
  logic             AUX_POL, AUX_WEN, FB1_MODE, FB1_LEVEL, FB2_MODE, FB2_POL, FB3_MODE, FB3_POL;
  logic             SUPPLY_SRC_SEL, IRQ_POL, MAIN_BIT_WR, MAIN_BIT_WDATA, AUX_BIT_WR, AUX_BIT_WDATA;
  logic             SEQ_BUSY, SEQ_DONE, SEQ_DVC, IDLE_STATE, WAKE_VALID, BELOW_UPPER, BELOW_LOWER;
  logic             ADC_VALID, ADC_MON_EN, REG_OUT_RANGE, VIB_ACTIVE, EVT_READING;
  logic [ADC_W-1:0] ADC_RESULT, ADC_THRESH;
  logic [EVT_W-1:0] EVT_MASK, EVT_CLR, EVT_STATUS;
  // device outputs
  logic             FB2_O, FB2_OE, FB1_O, SUPPLY_LOW_N, IRQ_OUT, MAIN_EN_BIT, AUX_EN_BIT, FAULT_PD;
  logic             SEQ_PU_MAIN, SEQ_PU_AUX, SEQ_PD_MAIN, SEQ_PD_AUX, WAKEUP, WDOG_KICK, FULL_RESET, MOTOR_RUN;
  // partner requests and bench state
  logic             want_sys, want_main, want_aux, want_brake, kick_req, ka_busy, ast;
  logic [9:0]       v;
  logic [31:0]      rng = 32'h00014A8B;
  int               bad_count = 0, compares = 0, acnt = 0;
  int               n_pum = 0, n_pua = 0, n_pda = 0, n_pdm = 0, n_wk = 0, n_kick = 0, n_fpd = 0;

  host_ctrl #(.WAKE_MIN(WMIN)) dut (.CLK, .RST_N, .MAIN_EN_PIN, .AUX_EN_PIN, .FB2_I, .FB2_O, .FB2_OE, .FB3_I,
    .FB1_O, .SUPPLY_LOW_N, .IRQ_OUT, .MAIN_POL, .MAIN_WEN, .AUX_POL, .AUX_WEN, .FB1_MODE, .FB1_LEVEL, .FB2_MODE,
    .FB2_POL, .FB3_MODE, .FB3_POL, .SUPPLY_SRC_SEL, .IRQ_POL, .MAIN_BIT_WR, .MAIN_BIT_WDATA, .AUX_BIT_WR,
    .AUX_BIT_WDATA, .MAIN_EN_BIT, .AUX_EN_BIT, .SYSTEM_DOMAIN_ENABLE_PIN_BIT, .SEQ_BUSY, .SEQ_DONE, .SEQ_DVC, .IDLE_STATE,
    .WAKE_VALID, .SEQ_PU_MAIN, .SEQ_PU_AUX, .SEQ_PD_MAIN, .SEQ_PD_AUX, .WAKEUP, .WDOG_KICK, .BELOW_UPPER,
    .BELOW_LOWER, .ADC_VALID, .ADC_RESULT, .ADC_THRESH, .ADC_MON_EN, .REG_OUT_RANGE, .FAULT_PD, .FULL_RESET,
    .VIB_ACTIVE, .MOTOR_RUN, .EVT_MASK, .EVT_CLR, .EVT_READING, .EVT_STATUS);
  host_model #(.KA_HALF(3000)) host (.clk(CLK), .want_sys(want_sys), .want_main(want_main),
    .want_aux(want_aux), .want_brake(want_brake), .kick_req(kick_req), .system_domain_enable_pin(SYSTEM_DOMAIN_ENABLE_PIN_BIT),
    .main_pin(MAIN_EN_PIN), .aux_pin(AUX_EN_PIN), .brake_pin(FB3_I), .ka_pin(FB2_I), .ka_busy(ka_busy));

  // 40 MHz clock
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  // tally one-cycle pulses from the device
  always @(posedge CLK) begin
    if (SEQ_PU_MAIN === 1'b1) n_pum++;
    if (SEQ_PU_AUX === 1'b1) n_pua++;
    if (SEQ_PD_AUX === 1'b1) n_pda++;
    if (SEQ_PD_MAIN === 1'b1) n_pdm++;
    if (WAKEUP === 1'b1) n_wk++;
    if (WDOG_KICK === 1'b1) n_kick++;
    if (FAULT_PD === 1'b1) n_fpd++;
  end

  // xorshift generator, fixed seed keeps runs repeatable
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // interrupt pin level for a polarity and a pending state
  function automatic logic irq_exp(input logic pol, input logic act);
    return pol ? act : !act;
  endfunction

  // filter model: state flips on the third consecutive opposite result
  function automatic logic adc_exp(input logic below);
    if (below != ast) acnt++;
    else acnt = 0;
    if (acnt == ADC_CONSEC) begin
      ast = below;
      acnt = 0;
    end
    return ast;
  endfunction

  // verdict and end of run, also reached by any timeout
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // let n edges pass, then step clear of their updates
  task automatic settle(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  // compare a device value
  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // compare a pulse count
  task automatic chkn(input int g, input int e);
    chk(10'(g), 10'(e));
  endtask

  task automatic clr(input logic [2:0] m);
    @(posedge CLK);
    EVT_CLR <= m;
    @(posedge CLK);
    EVT_CLR <= 3'h0;
    settle(2);
  endtask

  task automatic wr_main(input logic d);
    @(posedge CLK);
    MAIN_BIT_WR <= 1'b1;
    MAIN_BIT_WDATA <= d;
    @(posedge CLK);
    MAIN_BIT_WR <= 1'b0;
    settle(3);
  endtask

  // one ADC result, then the pin level one cycle after the filter
  task automatic adc_sample(input logic [9:0] r);
    logic e;
    @(posedge CLK);
    ADC_VALID <= 1'b1;
    ADC_RESULT <= r;
    @(posedge CLK);
    ADC_VALID <= 1'b0;
    e = adc_exp(r < ADC_THRESH);
    settle(2);
    chk(SUPPLY_LOW_N, !e);
  endtask

  // bounded wait for the host keep-alive cycle to finish
  task automatic wait_ka;
    int i;
    settle(1);
    for (i = 0; i < 20000 && ka_busy; i++)
      @(posedge CLK);
    if (ka_busy) begin
      bad_count++;
      close_out;
    end
  endtask

  // hang guard well above the expected run length
  initial begin
    #2_500_000;
    bad_count++;
    close_out;
  end

  initial begin
    {MAIN_POL, AUX_POL, FB2_POL, FB3_POL, ADC_MON_EN, ast} = 6'h3E;
    {MAIN_WEN, AUX_WEN, FB1_MODE, FB1_LEVEL, FB2_MODE, FB3_MODE, SUPPLY_SRC_SEL, IRQ_POL} = 8'h00;
    {MAIN_BIT_WR, MAIN_BIT_WDATA, AUX_BIT_WR, AUX_BIT_WDATA, SEQ_BUSY, SEQ_DONE, SEQ_DVC} = 7'h00;
    {IDLE_STATE, WAKE_VALID, BELOW_UPPER, BELOW_LOWER, ADC_VALID, REG_OUT_RANGE, VIB_ACTIVE} = 7'h00;
    {EVT_READING, RST_N, want_sys, want_main, want_aux, want_brake, kick_req} = 7'h00;
    {ADC_RESULT, ADC_THRESH, EVT_MASK, EVT_CLR} = {10'h000, 10'h200, 3'h0, 3'h0};
    repeat (10) @(posedge CLK);
    RST_N <= 1'b1;
    settle(3);
    chk(IRQ_OUT, irq_exp(1'b0, 1'b0));
    chk(EVT_STATUS, 3'h0);
    // main pin activation from idle with its wake enable set
    @(posedge CLK);
    {IDLE_STATE, MAIN_WEN, want_sys, want_main} <= 4'hF;
    settle(10);
    chk(MAIN_EN_BIT, 1'b1);
    chkn(n_pum, 1);
    chkn(n_wk, 1);
    chk(EVT_STATUS, 3'h1);
    chk(IRQ_OUT, irq_exp(1'b0, 1'b1));
    // aux pin without wake enable: bit and event, no wakeup
    @(posedge CLK);
    want_aux <= 1'b1;
    settle(10);
    chk(AUX_EN_BIT, 1'b1);
    chkn(n_pua, 1);
    chkn(n_wk, 1);
    chk(EVT_STATUS, 3'h3);
    @(posedge CLK);
    IRQ_POL <= 1'b1;
    settle(2);
    chk(IRQ_OUT, irq_exp(1'b1, 1'b1));
    @(posedge CLK);
    IRQ_POL <= 1'b0;
    clr(3'h1);
    chk(IRQ_OUT, irq_exp(1'b0, 1'b1));
    clr(3'h2);
    chk(IRQ_OUT, irq_exp(1'b0, 1'b0));
    // main off: aux then main power-down, no event
    @(posedge CLK);
    IDLE_STATE <= 1'b0;
    want_main <= 1'b0;
    settle(8);
    chk(MAIN_EN_BIT, 1'b0);
    chk(AUX_EN_BIT, 1'b0);
    chkn(n_pda, 1);
    chkn(n_pdm, 0);
    chk(EVT_STATUS, 3'h0);
    @(posedge CLK);
    SEQ_DONE <= 1'b1;
    @(posedge CLK);
    SEQ_DONE <= 1'b0;
    settle(3);
    chkn(n_pdm, 1);
    // register mirror, then a write dropped while the sequencer is busy
    wr_main(1'b1);
    chk(MAIN_EN_BIT, 1'b1);
    chkn(n_pum, 2);
    @(posedge CLK);
    SEQ_BUSY <= 1'b1;
    wr_main(1'b0);
    @(posedge CLK);
    SEQ_BUSY <= 1'b0;
    settle(3);
    chk(MAIN_EN_BIT, 1'b1);
    chkn(n_pda, 1);
    // supply warning during slot processing, then held through an event read
    @(posedge CLK);
    {IDLE_STATE, SEQ_BUSY, BELOW_UPPER} <= 3'h7;
    settle(6);
    chk(SUPPLY_LOW_N, 1'b0);
    chkn(n_fpd, 1);
    chkn(n_wk, 2);
    chk(EVT_STATUS, 3'h0);
    @(posedge CLK);
    {SEQ_BUSY, EVT_READING} <= 2'h1;
    settle(3);
    chk(EVT_STATUS, 3'h0);
    @(posedge CLK);
    {EVT_READING, IDLE_STATE} <= 2'h0;
    settle(3);
    chk(EVT_STATUS, 3'h4);
    chk(IRQ_OUT, irq_exp(1'b0, 1'b1));
    @(posedge CLK);
    EVT_MASK <= 3'h4;
    settle(2);
    chk(IRQ_OUT, irq_exp(1'b0, 1'b0));
    @(posedge CLK);
    EVT_MASK <= 3'h0;
    clr(3'h4);
    chk(IRQ_OUT, irq_exp(1'b0, 1'b0));
    @(posedge CLK);
    BELOW_LOWER <= 1'b1;
    settle(4);
    chk(FULL_RESET, 1'b1);
    // ADC source: boundary corners first, then random results
    @(posedge CLK);
    {BELOW_LOWER, BELOW_UPPER, SUPPLY_SRC_SEL} <= 3'h1;
    for (int i = 0; i < 60; i++) begin
      rng = xs(rng);
      v = (i < 6) ? CORNER[i] : rng[9:0];
      adc_sample(v);
    end
    // wakeup indication pulse, then level and ready mode
    @(posedge CLK);
    {want_sys, FB1_LEVEL, IDLE_STATE, WAKE_VALID} <= 4'h7;
    @(posedge CLK);
    {IDLE_STATE, WAKE_VALID} <= 2'h0;
    settle(2);
    chk(FB1_O, 1'b1);
    settle(WMIN - 5);
    chk(FB1_O, 1'b1);
    settle(10);
    chk(FB1_O, 1'b1);
    @(posedge CLK);
    want_sys <= 1'b1;
    settle(3);
    chk(FB1_O, 1'b0);
    @(posedge CLK);
    FB1_LEVEL <= 1'b0;
    settle(2);
    chk(FB1_O, 1'b1);
    @(posedge CLK);
    {FB1_MODE, SEQ_DVC} <= 2'h3;
    settle(2);
    chk(FB1_O, 1'b0);
    @(posedge CLK);
    {SEQ_DVC, SEQ_BUSY} <= 2'h1;
    settle(2);
    chk(FB1_O, 1'b0);
    @(posedge CLK);
    SEQ_BUSY <= 1'b0;
    settle(2);
    chk(FB1_O, 1'b1);
    // regulators-good over every monitor and range combination
    for (int i = 0; i < 4; i++) begin
      @(posedge CLK);
      {ADC_MON_EN, REG_OUT_RANGE} <= 2'(i);
      settle(2);
      chk(FB2_OE, !(i[1] && !i[0]));
    end
    chk(FB2_O, 1'b0);
    // two keep-alive cycles
    @(posedge CLK);
    FB2_MODE <= 1'b1;
    repeat (2) begin
      @(posedge CLK);
      kick_req <= 1'b1;
      @(posedge CLK);
      kick_req <= 1'b0;
      wait_ka;
    end
    settle(4);
    chkn(n_kick, 2);
    chk(FB2_OE, 1'b0);
    // motor over every vibrator, brake mode and brake level combination
    for (int i = 0; i < 8; i++) begin
      @(posedge CLK);
      {VIB_ACTIVE, FB3_MODE, want_brake} <= 3'(i);
      settle(6);
      chk(MOTOR_RUN, i[2] && !(i[1] && i[0]));
    end
    // aux pin re-activated from idle with its wake enable set, then its bit written off
    @(posedge CLK);
    {want_aux, AUX_WEN, IDLE_STATE} <= 3'h3;
    settle(6);
    @(posedge CLK);
    want_aux <= 1'b1;
    settle(8);
    chkn(n_wk, 3);
    chkn(n_pua, 2);
    chk(EVT_STATUS, 3'h2);
    @(posedge CLK);
    {AUX_BIT_WR, AUX_BIT_WDATA} <= 2'h2;
    @(posedge CLK);
    AUX_BIT_WR <= 1'b0;
    settle(2);
    chk(AUX_EN_BIT, 1'b0);
    chkn(n_pda, 2);
    close_out;
  end
endmodule
`default_nettype wire
